// ### drc_config.sv
// Purpose: Serial-loaded two-bank configuration store of a radio transceiver.
// Assumes: Serial clock, data, strobe and the mode pins are asynchronous to I_CLOCK.
// Notes:   The serial clock is oversampled; it must stay well below I_CLOCK / 4.
// Operation
// - Amplifier field: 01 low gain, 11 normal.
// - Single bits enable mixer, IF, limiter, others.
// - Route bit selects demodulator or strength path.
// - Power amp field sets attenuation, enables modulation.
// - Synthesizer bit enables whole synthesizer group.
// - Demodulator auto-enabled by limiter, lowpass, FSK route.
// - Bank zero frequency: 22 bits, reset zero.
// - Bank one frequency: 22 bits, reset zero.
// - Shared 8-bit deviation in bank zero control.
// - Slicer hold or learning mode select bit.
// - Three-bit acceleration factor, reset zero.
// - Divider select bit: 256 or 512.
// - Modulation select; host never writes one.
// - Synthesizer word: bank frequency, plus four deviations when modulation is on and TX data is one.
// - Standby low powers down; programming still works.
// - Each bank stores frequency and enables independently.
// - Bank-select pin level picks active bank.
// - Rising serial clock shifts data, MSB first.
// - Strobe rise loads latch chosen by address.
// - Only last twenty-four bits are kept.
// - Test latch address 111; zero data clears.
module drc_config (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RSTN,
  input  wire logic        I_SER_CLOCK,
  input  wire logic        I_SER_DATA,
  input  wire logic        I_SER_STROBE,
  input  wire logic        I_STANDBY_N_PIN,
  input  wire logic        I_BANK_SELECT,
  input  wire logic        I_TX_DATA,
  output logic             O_LNA_ON,
  output logic             O_LNA_LOW_GAIN,
  output logic             O_MIXER_ON,
  output logic             O_IF_AMP_ON,
  output logic             O_LIMITER_ON,
  output logic             O_STRENGTH_ON,
  output logic             O_ROUTE_TO_STRENGTH,
  output logic             O_LOWPASS_ON,
  output logic             O_SLICER_ON,
  output logic [1:0]       O_POWER_AMP_MODE,
  output logic             O_TX_MOD_ON,
  output logic             O_OSCILLATOR_ON,
  output logic             O_SYNTH_ON,
  output logic             O_DEMOD_ON,
  output logic             O_SLICER_LEARN,
  output logic [2:0]       O_ACCEL_FACTOR,
  output logic             O_DIVIDE_512,
  output logic             O_MODULATION_SELECT,
  output logic [23:0]      O_SYNTH_WORD,
  output logic             O_TEST_MODE
);
  // ==========================================================================
  // Input synchronisers
  logic [2:0] sclk_sync_ff;
  logic [1:0] sdat_sync_ff;
  logic [2:0] strb_sync_ff;
  logic [1:0] stby_sync_ff;
  logic [1:0] bank_sync_ff;
  logic [1:0] txd_sync_ff;
  logic       sclk_rise;
  logic       strb_rise;
  logic       run;
  logic       bank;

  // Data takes the same two stages as the clock so the edge sees the bit it framed.
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sclk_sync_ff <= 3'h0;
      sdat_sync_ff <= 2'h0;
      strb_sync_ff <= 3'h0;
      stby_sync_ff <= 2'h0;
      bank_sync_ff <= 2'h0;
      txd_sync_ff  <= 2'h0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], I_SER_CLOCK};
      sdat_sync_ff <= {sdat_sync_ff[0], I_SER_DATA};
      strb_sync_ff <= {strb_sync_ff[1:0], I_SER_STROBE};
      stby_sync_ff <= {stby_sync_ff[0], I_STANDBY_N_PIN};
      bank_sync_ff <= {bank_sync_ff[0], I_BANK_SELECT};
      txd_sync_ff  <= {txd_sync_ff[0], I_TX_DATA};
    end
  end

  assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
  assign strb_rise = strb_sync_ff[1] & ~strb_sync_ff[2];
  assign run       = stby_sync_ff[1];
  assign bank      = bank_sync_ff[1];

  // ==========================================================================
  // Shift register
  logic [drc_pkg::WORD_W-1:0] shift_ff;

  // Older bits fall off the top, so only the last full word survives.
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      shift_ff <= 24'h000000;
    end else if (sclk_rise) begin
      shift_ff <= {shift_ff[drc_pkg::WORD_W-2:0], sdat_sync_ff[1]};
    end
  end

  // ==========================================================================
  // Latches
  logic [1:0]                 sel;
  logic                       ld_f0;
  logic                       ld_f1;
  logic                       ld_c1;
  logic                       ld_c0;
  logic                       ld_t;
  logic [drc_pkg::CTL_W-1:0]  ctl0_ff;
  logic [drc_pkg::CTL_W-1:0]  ctl1_ff;
  logic [drc_pkg::FREQ_W-1:0] freq0_ff;
  logic [drc_pkg::FREQ_W-1:0] freq1_ff;
  logic [drc_pkg::DEV_W-1:0]  dev_ff;
  logic                       learn_ff;
  logic                       mod_sel_ff;
  logic                       div_ff;
  logic [2:0]                 accel_ff;
  logic [drc_pkg::TEST_W-1:0] test_ff;

  assign sel   = shift_ff[drc_pkg::SEL_HI:drc_pkg::SEL_LO];
  assign ld_f0 = strb_rise & (sel == drc_pkg::SEL_B0_FREQ);
  assign ld_f1 = strb_rise & (sel == drc_pkg::SEL_B1_FREQ);
  assign ld_c1 = strb_rise & (sel == drc_pkg::SEL_B1_CTL);
  assign ld_c0 = strb_rise & (sel == drc_pkg::SEL_HIGH)
               & (shift_ff[drc_pkg::SUB_BIT] == drc_pkg::SUB_B0_CTL);
  assign ld_t  = strb_rise & (sel == drc_pkg::SEL_HIGH)
               & (shift_ff[drc_pkg::SUB_BIT] != drc_pkg::SUB_B0_CTL);

  // Loading works in standby too, so words can be preloaded before operation.
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      freq0_ff <= drc_pkg::FREQ_RST;
      freq1_ff <= drc_pkg::FREQ_RST;
    end else begin
      if (ld_f0) begin
        freq0_ff <= shift_ff[drc_pkg::FREQ_W-1:0];
      end
      if (ld_f1) begin
        freq1_ff <= shift_ff[drc_pkg::FREQ_W-1:0];
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctl0_ff <= drc_pkg::CTL_RST;
      dev_ff  <= drc_pkg::DEV_RST;
    end else if (ld_c0) begin
      ctl0_ff <= shift_ff[drc_pkg::CTL_W-1:0];
      dev_ff  <= shift_ff[drc_pkg::DEV_HI:drc_pkg::DEV_LO];
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctl1_ff    <= drc_pkg::CTL_RST;
      learn_ff   <= 1'h0;
      mod_sel_ff <= drc_pkg::MM_FSK;
      div_ff     <= 1'h0;
      accel_ff   <= drc_pkg::ACQUISITION_ACCEL_FACTOR_RST;
    end else if (ld_c1) begin
      ctl1_ff    <= shift_ff[drc_pkg::CTL_W-1:0];
      learn_ff   <= shift_ff[drc_pkg::SLICER_LEARN_SELECT_BIT];
      mod_sel_ff <= shift_ff[drc_pkg::MM_BIT];
      div_ff     <= shift_ff[drc_pkg::LOOP_DIVIDER_SELECT_BIT];
      accel_ff   <= shift_ff[drc_pkg::ACQUISITION_ACCEL_FACTOR_HI:drc_pkg::ACQUISITION_ACCEL_FACTOR_LO];
    end
  end

  // Any nonzero payload arms the test latch; an all-zero payload or a reset clears it again.
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      test_ff <= drc_pkg::TEST_CLEAR;
    end else if (ld_t) begin
      test_ff <= shift_ff[drc_pkg::TEST_W-1:0];
    end
  end

  // ==========================================================================
  // Active bank and outputs
  logic [drc_pkg::CTL_W-1:0]  act;
  logic [drc_pkg::FREQ_W-1:0] act_freq;
  logic [1:0]                 pa;
  logic                       mod_on;
  logic [23:0]                dev_step;

  // A plain mux keeps bank switching free of any serial edge.
  assign act      = bank ? ctl1_ff : ctl0_ff;
  assign act_freq = bank ? freq1_ff : freq0_ff;
  assign pa       = run ? act[drc_pkg::PA_HI:drc_pkg::PA_LO] : drc_pkg::PA_OFF;
  assign mod_on   = (pa != drc_pkg::PA_OFF) & (mod_sel_ff == drc_pkg::MM_FSK);
  assign dev_step = 24'(dev_ff) << drc_pkg::DEV_SHIFT;

  assign O_LNA_ON            = run & act[drc_pkg::LNA_LO];
  assign O_LNA_LOW_GAIN      = run
                             & (act[drc_pkg::LNA_HI:drc_pkg::LNA_LO] == drc_pkg::LNA_LOW_GAIN);
  assign O_MIXER_ON          = run & act[drc_pkg::MIX_BIT];
  assign O_IF_AMP_ON         = run & act[drc_pkg::IF_BIT];
  assign O_LIMITER_ON        = run & act[drc_pkg::LIM_BIT];
  assign O_STRENGTH_ON       = run & act[drc_pkg::RSSI_BIT];
  assign O_ROUTE_TO_STRENGTH = act[drc_pkg::ROUTE_BIT];
  assign O_LOWPASS_ON        = run & act[drc_pkg::LPF_BIT];
  assign O_SLICER_ON         = run & act[drc_pkg::SLC_BIT];
  assign O_POWER_AMP_MODE    = pa;
  assign O_TX_MOD_ON         = mod_on;
  assign O_OSCILLATOR_ON     = run & act[drc_pkg::OSC_BIT];
  assign O_SYNTH_ON          = run & act[drc_pkg::PLL_BIT];
  assign O_DEMOD_ON          = run & act[drc_pkg::LIM_BIT] & act[drc_pkg::LPF_BIT]
                             & ~act[drc_pkg::ROUTE_BIT];
  assign O_SLICER_LEARN      = learn_ff;
  assign O_ACCEL_FACTOR      = accel_ff;
  assign O_DIVIDE_512        = div_ff;
  assign O_MODULATION_SELECT = mod_sel_ff;
  assign O_TEST_MODE         = (test_ff != drc_pkg::TEST_CLEAR);
  // Deviation is only added while modulation is live, so receive keeps a clean word.
  assign O_SYNTH_WORD        = 24'(act_freq)
                             + ((mod_on & txd_sync_ff[1]) ? dev_step : 24'h000000);

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);

  sequence s_load(logic [1:0] code);
    strb_rise && sel == code;
  endsequence

  a_shift_capture: assert property (sclk_rise |=>
      shift_ff == {$past(shift_ff[drc_pkg::WORD_W-2:0]), $past(sdat_sync_ff[1])})
    else $error("Shift register missed a serial bit.");
  a_freq0_load: assert property (s_load(drc_pkg::SEL_B0_FREQ) |=>
      freq0_ff == $past(shift_ff[drc_pkg::FREQ_W-1:0]) && $stable(freq1_ff))
    else $error("Bank zero frequency not loaded alone.");
  a_ctl1_load: assert property (s_load(drc_pkg::SEL_B1_CTL) |=>
      div_ff == $past(shift_ff[drc_pkg::LOOP_DIVIDER_SELECT_BIT]) && $stable(ctl0_ff))
    else $error("Bank one control word load failed.");
  a_bank_mux: assert property (run && bank |->
      O_SYNTH_ON == ctl1_ff[drc_pkg::PLL_BIT] && O_MIXER_ON == ctl1_ff[drc_pkg::MIX_BIT])
    else $error("Bank one not applied by select pin.");
  a_standby_off: assert property (!run |->
      !O_SYNTH_ON && !O_LNA_ON && O_POWER_AMP_MODE == drc_pkg::PA_OFF && !O_DEMOD_ON)
    else $error("Block enabled during standby.");
  a_demod_auto: assert property (run && O_LIMITER_ON && O_LOWPASS_ON |->
      O_DEMOD_ON == !O_ROUTE_TO_STRENGTH)
    else $error("Demodulator enable wrong.");
  a_lna_decode: assert property (O_LNA_LOW_GAIN |-> O_LNA_ON && !act[drc_pkg::LNA_HI])
    else $error("Amplifier low gain decode wrong.");
  a_synth_word: assert property (run && mod_on && txd_sync_ff[1] && !bank |->
      O_SYNTH_WORD == 24'(freq0_ff) + 24'(dev_ff) * 24'h000004)
    else $error("Deviation offset not added.");
  a_test_clear: assert property (ld_t
      && shift_ff[drc_pkg::TEST_W-1:0] == drc_pkg::TEST_CLEAR |=> !O_TEST_MODE)
    else $error("Test latch not cleared.");
  a_one_latch: assert property (strb_rise |->
      $onehot({ld_f0, ld_f1, ld_c1, ld_c0, ld_t}))
    else $error("Strobe did not pick exactly one latch.");

  // ==========================================================================
  // Assertions on stored words and the active bank
  // Stored words may move only on their own strobe, or a bank switch would need a rewrite.
  a_store_hold: assert property (!strb_rise |=>
      $stable(freq0_ff) && $stable(freq1_ff) && $stable(ctl0_ff) && $stable(ctl1_ff))
    else $error("Stored bank setting changed without a load.");
  a_shift_hold: assert property (!sclk_rise |=> $stable(shift_ff))
    else $error("Shift register moved without a serial edge.");
  a_freq1_load: assert property (s_load(drc_pkg::SEL_B1_FREQ) |=>
      freq1_ff == $past(shift_ff[drc_pkg::FREQ_W-1:0]) && $stable(freq0_ff))
    else $error("Bank one frequency not loaded alone.");
  a_ctl0_load: assert property (ld_c0 |=>
      dev_ff == $past(shift_ff[drc_pkg::DEV_HI:drc_pkg::DEV_LO]) && $stable(ctl1_ff))
    else $error("Bank zero control word load failed.");
  a_ctl1_fields: assert property (s_load(drc_pkg::SEL_B1_CTL) |=>
      accel_ff == $past(shift_ff[drc_pkg::ACQUISITION_ACCEL_FACTOR_HI:drc_pkg::ACQUISITION_ACCEL_FACTOR_LO])
      && learn_ff == $past(shift_ff[drc_pkg::SLICER_LEARN_SELECT_BIT])
      && mod_sel_ff == $past(shift_ff[drc_pkg::MM_BIT]))
    else $error("Bank one shared fields not loaded.");
  a_bank0_mux: assert property (run && !bank |->
      O_SYNTH_ON == ctl0_ff[drc_pkg::PLL_BIT] && O_SLICER_ON == ctl0_ff[drc_pkg::SLC_BIT])
    else $error("Bank zero not applied by select pin.");
  a_bank1_enables: assert property (run && bank |->
      O_LIMITER_ON == ctl1_ff[drc_pkg::LIM_BIT] && O_STRENGTH_ON == ctl1_ff[drc_pkg::RSSI_BIT])
    else $error("Bank one block enables wrong.");
  a_route_bit: assert property (
      O_ROUTE_TO_STRENGTH == (bank ? ctl1_ff[drc_pkg::ROUTE_BIT] : ctl0_ff[drc_pkg::ROUTE_BIT]))
    else $error("Route switch does not follow the active bank.");
  a_pa_mode: assert property (run |->
      O_POWER_AMP_MODE == act[drc_pkg::PA_HI:drc_pkg::PA_LO]
      && O_TX_MOD_ON == (O_POWER_AMP_MODE != drc_pkg::PA_OFF && !O_MODULATION_SELECT))
    else $error("Power amplifier mode or modulation enable wrong.");
  a_lna_normal: assert property (act[drc_pkg::LNA_HI] && act[drc_pkg::LNA_LO] |->
      O_LNA_ON == run && !O_LNA_LOW_GAIN)
    else $error("Amplifier normal mode decode wrong.");
  a_synth_plain: assert property (!txd_sync_ff[1] |-> O_SYNTH_WORD == 24'(act_freq))
    else $error("Synthesizer word differs from the active bank frequency.");
  a_synth_bank1: assert property (run && mod_on && txd_sync_ff[1] && bank |->
      O_SYNTH_WORD == 24'(freq1_ff) + 24'(dev_ff) * 24'h000004)
    else $error("Deviation offset not added in bank one.");
  a_test_set: assert property (ld_t
      && shift_ff[drc_pkg::TEST_W-1:0] != drc_pkg::TEST_CLEAR |=> O_TEST_MODE)
    else $error("Test latch not armed.");
endmodule

// ### drc_pkg.sv
// Purpose: Shared constants for the dual bank radio configuration store.
// Assumes: 24-bit serial words, sent most significant bit first.
// Notes:   Field positions are those of the control and frequency words.
package drc_pkg;
  // ==========================================================================
  // Serial word layout
  localparam int WORD_W = 24;
  localparam int SEL_HI = 23;
  localparam int SEL_LO = 22;
  localparam int SUB_BIT = 21;
  localparam logic [1:0] SEL_B0_FREQ = 2'h0;
  localparam logic [1:0] SEL_B1_FREQ = 2'h1;
  localparam logic [1:0] SEL_B1_CTL = 2'h2;
  localparam logic [1:0] SEL_HIGH = 2'h3;
  localparam logic SUB_B0_CTL = 1'h0;
  localparam int TEST_W = 21;
  localparam logic [TEST_W-1:0] TEST_CLEAR = 21'h0;
  // ==========================================================================
  // Per-bank block enable fields
  localparam int CTL_W = 13;
  localparam int LNA_HI = 1;
  localparam int LNA_LO = 0;
  localparam int MIX_BIT = 2;
  localparam int IF_BIT = 3;
  localparam int LIM_BIT = 4;
  localparam int RSSI_BIT = 5;
  localparam int ROUTE_BIT = 6;
  localparam int LPF_BIT = 7;
  localparam int SLC_BIT = 8;
  localparam int PA_HI = 10;
  localparam int PA_LO = 9;
  localparam int OSC_BIT = 11;
  localparam int PLL_BIT = 12;
  localparam logic [1:0] LNA_LOW_GAIN = 2'h1;
  localparam logic [1:0] PA_OFF = 2'h0;
  localparam logic [CTL_W-1:0] CTL_RST = 13'h0;
  // ==========================================================================
  // Shared fields
  localparam int FREQ_W = 22;
  localparam int DEV_HI = 20;
  localparam int DEV_LO = 13;
  localparam int DEV_W = 8;
  localparam int DEV_SHIFT = 2;
  localparam int SLICER_LEARN_SELECT_BIT = 15;
  localparam int MM_BIT = 16;
  localparam int LOOP_DIVIDER_SELECT_BIT = 17;
  localparam int ACQUISITION_ACCEL_FACTOR_HI = 20;
  localparam int ACQUISITION_ACCEL_FACTOR_LO = 18;
  localparam logic [FREQ_W-1:0] FREQ_RST = 22'h0;
  localparam logic [DEV_W-1:0] DEV_RST = 8'h00;
  localparam logic [2:0] ACQUISITION_ACCEL_FACTOR_RST = 3'h0;
  localparam logic MM_FSK = 1'h0;
endpackage

// ### drc_host.sv
// Purpose: Host side of the three-wire write-only programming link.
// Assumes: I_CLOCK is the bench clock; one link bit takes 8 of its periods.
// Notes:   The link clock stands low between words, as a real host leaves it.
module drc_host (
  input  wire logic I_CLOCK,
  output logic      O_SER_CLOCK,
  output logic      O_SER_DATA,
  output logic      O_SER_STROBE
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    O_SER_CLOCK  <= 1'b0;
    O_SER_DATA   <= 1'b0;
    O_SER_STROBE <= 1'b0;
  end
  // ==========================================================================
  // Link transfers, entered just after a rising edge of I_CLOCK
  task automatic shift_bit(input logic b);
    O_SER_DATA <= b;
    repeat (4) @(posedge I_CLOCK);
    O_SER_CLOCK <= 1'b1;
    repeat (4) @(posedge I_CLOCK);
    O_SER_CLOCK <= 1'b0;
  endtask
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      shift_bit(w[i]);
    end
    O_SER_DATA <= 1'b0;
    repeat (4) @(posedge I_CLOCK);
    O_SER_STROBE <= 1'b1;
    repeat (4) @(posedge I_CLOCK);
    O_SER_STROBE <= 1'b0;
    repeat (4) @(posedge I_CLOCK);
  endtask
endmodule

// ### testbench.sv
// Purpose: Self-checking bench for the two-bank radio configuration store.
// Assumes: Outputs settle within four clocks of a pin change or a strobe.
// Notes:   Expected values come from a shadow copy of every word written.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock, i_rstn, ser_clock, ser_data, ser_strobe, standby, bank, tx;
  logic [21:0] flags;
  logic [23:0] synth, w, ef;
  logic [21:0] b0f, b1f;
  logic [20:0] b0c, b1c, tst;
  logic [31:0] seed;
  int          mismatches, total_checks;
  drc_host i_host (.I_CLOCK(i_clock), .O_SER_CLOCK(ser_clock), .O_SER_DATA(ser_data),
    .O_SER_STROBE(ser_strobe));
  drc_config i_dut (.I_CLOCK(i_clock), .I_RSTN(i_rstn), .I_SER_CLOCK(ser_clock),
    .I_SER_DATA(ser_data), .I_SER_STROBE(ser_strobe), .I_STANDBY_N_PIN(standby),
    .I_BANK_SELECT(bank), .I_TX_DATA(tx), .O_LNA_ON(flags[21]), .O_LNA_LOW_GAIN(flags[20]),
    .O_MIXER_ON(flags[19]), .O_IF_AMP_ON(flags[18]), .O_LIMITER_ON(flags[17]),
    .O_STRENGTH_ON(flags[16]), .O_ROUTE_TO_STRENGTH(flags[15]), .O_LOWPASS_ON(flags[14]),
    .O_SLICER_ON(flags[13]), .O_POWER_AMP_MODE(flags[12:11]), .O_TX_MOD_ON(flags[10]),
    .O_OSCILLATOR_ON(flags[9]), .O_SYNTH_ON(flags[8]), .O_DEMOD_ON(flags[7]),
    .O_SLICER_LEARN(flags[6]), .O_ACCEL_FACTOR(flags[5:3]), .O_DIVIDE_512(flags[2]),
    .O_MODULATION_SELECT(flags[1]), .O_SYNTH_WORD(synth), .O_TEST_MODE(flags[0]));
  // ==========================================================================
  // Expectations
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  function automatic logic [21:0] exp_flags(input logic sb, input logic bk);
    logic [12:0] c;
    logic [1:0]  pa;
    c  = bk ? b1c[12:0] : b0c[12:0];
    pa = sb ? c[10:9] : 2'h0;
    return {sb & c[0], sb & (c[1:0] == 2'h1), sb & c[2], sb & c[3], sb & c[4], sb & c[5],
      c[6], sb & c[7], sb & c[8], pa, (pa != 2'h0) & ~b1c[16], sb & c[11], sb & c[12],
      sb & c[4] & c[7] & ~c[6], b1c[15], b1c[20:18], b1c[17], b1c[16], tst != 21'h0};
  endfunction
  function automatic logic [23:0] exp_synth(input logic sb, input logic bk, input logic t);
    logic [23:0] f;
    logic [1:0]  pa;
    f  = {2'h0, bk ? b1f : b0f};
    pa = bk ? b1c[10:9] : b0c[10:9];
    if (sb && (pa != 2'h0) && !b1c[16] && t) begin
      f = f + {14'h0, b0c[20:13], 2'h0};
    end
    return f;
  endfunction
  // ==========================================================================
  // Drivers and comparison
  task automatic cmp(input string name, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic write_word(input logic [23:0] wd, input int junk);
    @(posedge i_clock);
    repeat (junk) i_host.shift_bit(~wd[23]);
    i_host.send_word(wd);
    case (wd[23:22])
      2'h0: b0f = wd[21:0];
      2'h1: b1f = wd[21:0];
      2'h2: b1c = wd[20:0];
      default: if (wd[21]) tst = wd[20:0]; else b0c = wd[20:0];
    endcase
  endtask
  task automatic check_pins(input logic sb, input logic bk, input logic t);
    @(posedge i_clock);
    standby <= sb;
    bank    <= bk;
    tx      <= t;
    repeat (4) @(posedge i_clock);
    #1;
    ef = {2'h0, exp_flags(sb, bk)};
    cmp("flags", ef, {2'h0, flags});
    cmp("synth_word", exp_synth(sb, bk, t), synth);
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  initial begin
    repeat (40000) @(posedge i_clock);
    mismatches++;
    end_of_test();
  end
  initial begin
    {i_rstn, standby, bank, tx} = 4'h0;
    {b0f, b1f, b0c, b1c, tst} = '0;
    seed = 32'h1385;
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    check_pins(1'b1, 1'b1, 1'b1);
    write_word(24'hEFFFFF, 0);
    check_pins(1'b0, 1'b0, 1'b0);
    write_word(24'hE00000, 3);
    check_pins(1'b0, 1'b0, 1'b0);
    for (int it = 0; it < 12; it++) begin
      for (int k = 0; k < 4; k++) begin
        seed = lfsr(seed);
        w = (it == 0) ? 24'hFFFFFF : seed[23:0];
        w[23:22] = k[1:0];
        if (k == 3) w[21] = 1'b0;
        if (k == 2) w[16] = 1'b0;
        if (k >= 2) w[11] = 1'b1;
        write_word(w, int'(seed[31:30]));
      end
      for (int p = 0; p < 8; p++) begin
        check_pins(p[2], p[1], p[0]);
      end
    end
    // A second reset in mid-run must bring every stored field back to its power-up value.
    i_rstn <= 1'b0;
    {b0f, b1f, b0c, b1c, tst} = '0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    check_pins(1'b1, 1'b0, 1'b1);
    end_of_test();
  end
endmodule
